// [jesd_rx_tpl_pkg.sv]
// constants for the receive transport check, lane inversion and alignment capture
package jesd_rx_tpl_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANES = 8;
  localparam int LANE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SAMPLE_W = 16;

  localparam logic [11:0] OFS_TPL_TEST_CONTROL = 12'h32c;
  localparam logic [11:0] OFS_TPL_REFERENCE_LOW = 12'h32d;
  localparam logic [11:0] OFS_TPL_REFERENCE_HIGH = 12'h32e;
  localparam logic [11:0] OFS_TPL_RESULT = 12'h32f;
  localparam logic [11:0] OFS_LANE_INVERT_CONTROL = 12'h334;
  localparam logic [11:0] OFS_RX_CFG_DEVICE_ID = 12'h400;
  localparam logic [11:0] OFS_RX_CFG_BANK_ID = 12'h401;
  localparam logic [11:0] OFS_RX_CFG_LANE_ID_ADJUST = 12'h402;
  localparam logic [11:0] OFS_RX_CFG_SCRAMBLE_LANES = 12'h403;
  localparam logic [11:0] OFS_RX_CFG_OCTETS_PER_FRAME = 12'h404;

  // test control field positions
  localparam int POS_CHECK_ON = 0;
  localparam int POS_CHECK_CLEAR = 1;
  localparam int POS_CHANNEL_LSB = 2;
  localparam int POS_INDEX_LSB = 4;
  // alignment configuration field positions
  localparam int POS_ADJUST_DIR = 6;
  localparam int POS_PHASE_REQ = 5;
  localparam int POS_SCRAMBLE = 7;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : jesd_rx_tpl_pkg

// [lane_word_fifo.sv]
// synchronous flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module lane_word_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int IW = $clog2(DEPTH);
  localparam logic [IW:0] DEPTH_C = (IW+1)'(DEPTH);
  localparam logic [IW-1:0] LAST_C = (IW)'(DEPTH-1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic [IW:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire [IW:0] next_count = push && !pop ? count + 1'b1 : (pop && !push ? count - 1'b1 : count);

  assign out_data_out = mem[rd_idx];

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else
    begin
      count <= next_count;
      in_ready_out <= next_count != DEPTH_C;
      out_valid_out <= next_count != '0;
      if (push)
        wr_idx <= wr_idx == LAST_C ? '0 : wr_idx + 1'b1;
      if (pop)
        rd_idx <= rd_idx == LAST_C ? '0 : rd_idx + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem[wr_idx] <= in_data_in;
  end
endmodule : lane_word_fifo
`default_nettype wire

// [jesd_rx_tpl_test_ilas_readback.sv]
// receive transport self-check, lane polarity flip and lane 0 alignment capture
`timescale 1ns/1ns
`default_nettype none
module jesd_rx_tpl_test_ilas_readback
  import jesd_rx_tpl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [SAMPLE_W-1:0] tpl_sample_in,
  input wire logic [1:0] tpl_channel_in,
  input wire logic [3:0] tpl_index_in,
  input wire logic tpl_valid_in,
  output logic sample_mismatch_out,
  input wire logic [LANES*LANE_W-1:0] lane_data_in,
  input wire logic lane_valid_in,
  output logic lane_ready_out,
  output logic [LANES*LANE_W-1:0] lanes_data_out,
  output logic lanes_valid_out,
  input wire logic lanes_ready_in,
  input wire logic ilas_valid_in,
  input wire logic [7:0] ilas_device_ident_in,
  input wire logic [7:0] ilas_bank_ident_in,
  input wire logic ilas_adjust_direction_in,
  input wire logic ilas_phase_request_in,
  input wire logic [4:0] ilas_lane_ident_in,
  input wire logic ilas_scramble_flag_in,
  input wire logic [4:0] ilas_lane_count_in,
  input wire logic [7:0] ilas_octets_per_frame_in
);
  // software registers
  logic [7:0] tpl_test_control;
  logic [7:0] tpl_reference_low;
  logic [7:0] tpl_reference_high;
  logic [7:0] lane_invert_control;
  logic sample_mismatch_flag;
  // captured alignment configuration
  logic [7:0] received_device_ident;
  logic [7:0] received_bank_ident;
  logic received_adjust_direction;
  logic received_phase_request;
  logic [4:0] received_lane_ident;
  logic received_scramble_flag;
  logic [4:0] received_lane_count;
  logic [7:0] received_octets_per_frame;

  // register decode
  wire wr_control = reg_wr_in && reg_addr_in == OFS_TPL_TEST_CONTROL;
  wire wr_ref_low = reg_wr_in && reg_addr_in == OFS_TPL_REFERENCE_LOW;
  wire wr_ref_high = reg_wr_in && reg_addr_in == OFS_TPL_REFERENCE_HIGH;
  wire wr_invert = reg_wr_in && reg_addr_in == OFS_LANE_INVERT_CONTROL;

  // check controls
  wire tpl_check_on = tpl_test_control[POS_CHECK_ON];
  wire tpl_check_clear = tpl_test_control[POS_CHECK_CLEAR];
  wire [1:0] channel_select = tpl_test_control[POS_CHANNEL_LSB +: 2];
  wire [3:0] sample_index_select = tpl_test_control[POS_INDEX_LSB +: 4];
  wire [SAMPLE_W-1:0] expected_sample = {tpl_reference_high, tpl_reference_low};

  // transport output sample
  // only the sample at the receiver's transport output is looked at, never the converter core
  // sample and channel match
  wire sample_hit = tpl_valid_in && tpl_channel_in == channel_select && tpl_index_in == sample_index_select;
  wire sample_differs = sample_hit && tpl_sample_in != expected_sample;
  wire check_armed = tpl_check_on && !tpl_check_clear;

  // clear wins, mismatch latches
  // clear is a level, so an event during clear is dropped on purpose: the result must restart at pass
  wire next_mismatch = !check_armed ? 1'b0 : (sample_mismatch_flag || sample_differs);

  logic [LANES*LANE_W-1:0] flip_mask_wide;
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
      flip_mask_wide[i*LANE_W +: LANE_W] = {LANE_W{lane_invert_control[i]}};
  end
  wire [LANES*LANE_W-1:0] flipped_lanes = lane_data_in ^ flip_mask_wide;
  wire lane_push = lane_valid_in && lane_ready_out;

  // read mux
  wire [7:0] lane_id_adjust_byte = {1'b0, received_adjust_direction, received_phase_request, received_lane_ident};
  wire [7:0] scramble_lanes_byte = {received_scramble_flag, 2'b00, received_lane_count};
  logic [7:0] read_value;
  always_comb
  begin
    case (reg_addr_in)
      OFS_TPL_TEST_CONTROL: read_value = tpl_test_control;
      OFS_TPL_REFERENCE_LOW: read_value = tpl_reference_low;
      OFS_TPL_REFERENCE_HIGH: read_value = tpl_reference_high;
      OFS_TPL_RESULT: read_value = {7'h00, sample_mismatch_flag};
      OFS_LANE_INVERT_CONTROL: read_value = lane_invert_control;
      OFS_RX_CFG_DEVICE_ID: read_value = received_device_ident;
      OFS_RX_CFG_BANK_ID: read_value = received_bank_ident;
      OFS_RX_CFG_LANE_ID_ADJUST: read_value = lane_id_adjust_byte;
      OFS_RX_CFG_SCRAMBLE_LANES: read_value = scramble_lanes_byte;
      OFS_RX_CFG_OCTETS_PER_FRAME: read_value = received_octets_per_frame;
      default: read_value = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      tpl_test_control <= RST_BYTE;
      tpl_reference_low <= RST_BYTE;
      tpl_reference_high <= RST_BYTE;
      lane_invert_control <= RST_BYTE;
      reg_rdata_out <= RST_BYTE;
    end
    else
    begin
      if (wr_control)
        tpl_test_control <= reg_wdata_in;
      if (wr_ref_low)
        tpl_reference_low <= reg_wdata_in;
      if (wr_ref_high)
        tpl_reference_high <= reg_wdata_in;
      if (wr_invert)
        lane_invert_control <= reg_wdata_in;
      if (reg_rd_in)
        reg_rdata_out <= read_value;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      sample_mismatch_flag <= 1'b0;
      sample_mismatch_out <= 1'b0;
    end
    else
    begin
      sample_mismatch_flag <= next_mismatch;
      sample_mismatch_out <= next_mismatch;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      received_device_ident <= RST_BYTE;
      received_bank_ident <= RST_BYTE;
      received_adjust_direction <= 1'b0;
      received_phase_request <= 1'b0;
      received_lane_ident <= 5'h00;
      received_scramble_flag <= 1'b0;
      received_lane_count <= 5'h00;
      received_octets_per_frame <= RST_BYTE;
    end
    else if (ilas_valid_in)
    begin
      received_device_ident <= ilas_device_ident_in;
      received_bank_ident <= ilas_bank_ident_in;
      received_adjust_direction <= ilas_adjust_direction_in;
      received_phase_request <= ilas_phase_request_in;
      received_lane_ident <= ilas_lane_ident_in;
      received_scramble_flag <= ilas_scramble_flag_in;
      received_lane_count <= ilas_lane_count_in;
      received_octets_per_frame <= ilas_octets_per_frame_in;
    end
  end

  // eight deep buffer absorbs downstream stalls; its ready throttles the deserializer
  lane_word_fifo #(
    .WIDTH(LANES*LANE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_lane_fifo (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .in_data_in(flipped_lanes),
    .in_valid_in(lane_valid_in),
    .in_ready_out(lane_ready_out),
    .out_data_out(lanes_data_out),
    .out_valid_out(lanes_valid_out),
    .out_ready_in(lanes_ready_in)
  );

  // checks
  sequence s_write(logic [11:0] ofs);
    reg_wr_in && reg_addr_in == ofs;
  endsequence

  sequence s_armed_miss;
    check_armed && sample_differs;
  endsequence

  property p_clear_holds_pass;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      !check_armed |=> !sample_mismatch_out;
  endproperty
  a_clear_holds_pass: assert property (p_clear_holds_pass) else $error("fail flag set while check off or clearing");

  property p_miss_latches;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_armed_miss |=> sample_mismatch_flag ##1 (sample_mismatch_flag || !$past(check_armed));
  endproperty
  a_miss_latches: assert property (p_miss_latches) else $error("mismatch not latched");

  property p_match_keeps_pass;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (!sample_mismatch_flag && check_armed && !sample_differs) |=> !sample_mismatch_flag;
  endproperty
  a_match_keeps_pass: assert property (p_match_keeps_pass) else $error("flag set without a mismatch");

  property p_select_filters;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (!sample_mismatch_flag && tpl_valid_in && (tpl_channel_in != channel_select ||
        tpl_index_in != sample_index_select)) |=> !sample_mismatch_flag;
  endproperty
  a_select_filters: assert property (p_select_filters) else $error("unselected sample changed result");

  property p_enable_bits;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_write(OFS_TPL_TEST_CONTROL) |=> tpl_check_on == $past(reg_wdata_in[POS_CHECK_ON]) &&
        tpl_check_clear == $past(reg_wdata_in[POS_CHECK_CLEAR]);
  endproperty
  a_enable_bits: assert property (p_enable_bits) else $error("control bits not taken");

  property p_reference_word;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_write(OFS_TPL_REFERENCE_LOW) ##1 !reg_wr_in ##1 s_write(OFS_TPL_REFERENCE_HIGH) |=>
        expected_sample == {$past(reg_wdata_in), $past(reg_wdata_in, 3)};
  endproperty
  a_reference_word: assert property (p_reference_word) else $error("reference word wrong");

  property p_result_readback;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (reg_rd_in && reg_addr_in == OFS_TPL_RESULT) |=>
        reg_rdata_out == {7'h00, $past(sample_mismatch_flag)};
  endproperty
  a_result_readback: assert property (p_result_readback) else $error("result read wrong");

  property p_lane_flip;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (lane_push && !lanes_valid_out) |=> lanes_valid_out &&
        lanes_data_out == ($past(lane_data_in) ^ $past(flip_mask_wide));
  endproperty
  a_lane_flip: assert property (p_lane_flip) else $error("lane inversion wrong");

  property p_capture_ids;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      ilas_valid_in |=> received_device_ident == $past(ilas_device_ident_in) &&
        received_bank_ident == $past(ilas_bank_ident_in);
  endproperty
  a_capture_ids: assert property (p_capture_ids) else $error("identifiers not captured");

  property p_lane_byte;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      ilas_valid_in |=> lane_id_adjust_byte ==
        {1'b0, $past(ilas_adjust_direction_in), $past(ilas_phase_request_in), $past(ilas_lane_ident_in)};
  endproperty
  a_lane_byte: assert property (p_lane_byte) else $error("lane id byte wrong");

  property p_scramble_byte;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      ilas_valid_in |=>
        scramble_lanes_byte == {$past(ilas_scramble_flag_in), 2'b00, $past(ilas_lane_count_in)};
  endproperty
  a_scramble_byte: assert property (p_scramble_byte) else $error("scramble or lane count wrong");

  property p_octets;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      ilas_valid_in |=> received_octets_per_frame == $past(ilas_octets_per_frame_in);
  endproperty
  a_octets: assert property (p_octets) else $error("octets per frame wrong");

  property p_invert_write;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_write(OFS_LANE_INVERT_CONTROL) |=> lane_invert_control == $past(reg_wdata_in);
  endproperty
  a_invert_write: assert property (p_invert_write) else $error("lane inversion byte not taken");

  property p_ident_read_only;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (reg_wr_in && reg_addr_in == OFS_RX_CFG_DEVICE_ID && !ilas_valid_in) |=> $stable(received_device_ident);
  endproperty
  a_ident_read_only: assert property (p_ident_read_only) else $error("read-only identifier overwritten");
endmodule : jesd_rx_tpl_test_ilas_readback
`default_nettype wire

// [jesd_tx_model.sv]
// transmitter-side model: transport samples, lane words and lane 0 alignment fields
`timescale 1ns/1ns
`default_nettype none
module jesd_tx_model
  import jesd_rx_tpl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic lane_ready_in,
  output logic [SAMPLE_W-1:0] sample_out,
  output logic [1:0] channel_out,
  output logic [3:0] index_out,
  output logic sample_valid_out,
  output logic [LANES*LANE_W-1:0] lane_data_out,
  output logic lane_valid_out,
  output logic cfg_valid_out,
  output logic [7:0] dev_out,
  output logic [7:0] bank_out,
  output logic adj_out,
  output logic phase_out,
  output logic [4:0] lid_out,
  output logic scr_out,
  output logic [4:0] lcnt_out,
  output logic [7:0] oct_out
);
  initial
  begin
    {sample_out, channel_out, index_out, sample_valid_out, lane_data_out, lane_valid_out} = '0;
    {cfg_valid_out, dev_out, bank_out, adj_out, phase_out, lid_out, scr_out, lcnt_out, oct_out} = '0;
  end

  // released lines show the inverse, so a stale value never passes for a held one
  task send_sample(input logic [15:0] s, input logic [1:0] ch, input logic [3:0] ix);
    @(posedge clk_sys_in);
    #1 {sample_out, channel_out, index_out, sample_valid_out} = {s, ch, ix, 1'b1};
    @(posedge clk_sys_in);
    #1 {sample_out, channel_out, index_out, sample_valid_out} = {~s, ~ch, ~ix, 1'b0};
  endtask : send_sample

  task push(input logic [63:0] d, output bit ok);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    #1 {lane_data_out, lane_valid_out} = {d, 1'b1};
    // ready is registered, so its settled value is the one the next edge takes
    while (lane_ready_in !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys_in);
      #1;
    end
    @(posedge clk_sys_in);
    ok = (n < 50);
    #1 {lane_data_out, lane_valid_out} = {~d, 1'b0};
  endtask : push

  // lane count and octets are sent minus-one coded, octets only for 1, 2 or 4
  task send_cfg(input logic [7:0] dv, bk, input logic a, p, input logic [4:0] li,
                input logic sc, input logic [4:0] lc, input logic [7:0] f);
    @(posedge clk_sys_in);
    #1 {dev_out, bank_out, adj_out, phase_out, lid_out, scr_out, lcnt_out, oct_out} = {dv, bk, a, p, li, sc, lc, f};
    cfg_valid_out = 1'b1;
    @(posedge clk_sys_in);
    #1 {dev_out, bank_out, adj_out, phase_out, lid_out, scr_out, lcnt_out, oct_out} = ~{dv, bk, a, p, li, sc, lc, f};
    cfg_valid_out = 1'b0;
  endtask : send_cfg
endmodule : jesd_tx_model
`default_nettype wire

// [testbench.sv]
// self-checking bench: register access, transport compare, lane flip fifo, alignment capture
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import jesd_rx_tpl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lanes_ready = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [15:0] smp;
  logic [1:0] ch;
  logic [3:0] ix;
  logic sv, mis, lrdy, lv, lov, cv, adj, ph, scr;
  logic [63:0] ld, lod;
  logic [7:0] dev, bank, oct;
  logic [4:0] lid, lc;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [11:0] resets [10] = '{12'h32c, 12'h32d, 12'h32e, 12'h32f, 12'h334, 12'h400, 12'h401, 12'h402, 12'h403, 12'h404};
  logic [7:0] ctrl;
  logic [4:0] lcs [3] = '{5'h01, 5'h07, 5'h03};
  logic [7:0] fs [3] = '{8'h00, 8'h01, 8'h03};
  bit ok;

  jesd_rx_tpl_test_ilas_readback u_jesd_rx_tpl_test_ilas_readback (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .tpl_sample_in(smp), .tpl_channel_in(ch), .tpl_index_in(ix), .tpl_valid_in(sv), .sample_mismatch_out(mis),
    .lane_data_in(ld), .lane_valid_in(lv), .lane_ready_out(lrdy), .lanes_data_out(lod), .lanes_valid_out(lov),
    .lanes_ready_in(lanes_ready), .ilas_valid_in(cv), .ilas_device_ident_in(dev), .ilas_bank_ident_in(bank),
    .ilas_adjust_direction_in(adj), .ilas_phase_request_in(ph), .ilas_lane_ident_in(lid),
    .ilas_scramble_flag_in(scr), .ilas_lane_count_in(lc), .ilas_octets_per_frame_in(oct));

  jesd_tx_model u_jesd_tx_model (.clk_sys_in(clk_sys_in), .lane_ready_in(lrdy), .sample_out(smp),
    .channel_out(ch), .index_out(ix), .sample_valid_out(sv), .lane_data_out(ld), .lane_valid_out(lv),
    .cfg_valid_out(cv), .dev_out(dev), .bank_out(bank), .adj_out(adj), .phase_out(ph), .lid_out(lid),
    .scr_out(scr), .lcnt_out(lc), .oct_out(oct));

  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task give_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task check(input logic [63:0] got, exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      n_mismatch++;
    end
  endtask : check

  task bus(input logic [11:0] a, input logic [7:0] d, input logic w, r);
    @(posedge clk_sys_in);
    #1 {addr, wdata, wr, rd} = {a, d, w, r};
    @(posedge clk_sys_in);
    #1 {addr, wdata, wr, rd} = {~a, ~d, 2'b00};
  endtask : bus

  task wreg(input logic [11:0] a, input logic [7:0] d);
    bus(a, d, 1'b1, 1'b0);
  endtask : wreg

  task rchk(input logic [11:0] a, input logic [7:0] e);
    bus(a, 8'h00, 1'b0, 1'b1);
    check(rdata, e, "register read");
  endtask : rchk

  function automatic logic [63:0] flip(input logic [63:0] d, input logic [7:0] m);
    for (int n = 0; n < 8; n++)
      if (m[n])
        d[8*n+:8] = ~d[8*n+:8];
    return d;
  endfunction : flip

  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    foreach (resets[i])
      rchk(resets[i], 8'h00);
    check(lrdy, 1'b1, "ready after reset");
    wreg(OFS_TPL_REFERENCE_LOW, 8'h34);
    wreg(OFS_TPL_REFERENCE_HIGH, 8'h12);
    wreg(OFS_LANE_INVERT_CONTROL, 8'ha5);
    wreg(OFS_TPL_RESULT, 8'hff);
    wreg(12'h300, 8'hff);
    rchk(OFS_TPL_REFERENCE_LOW, 8'h34);
    rchk(OFS_TPL_REFERENCE_HIGH, 8'h12);
    rchk(OFS_LANE_INVERT_CONTROL, 8'ha5);
    rchk(OFS_TPL_RESULT, 8'h00);
    rchk(12'h300, UNMAPPED_READ);
    for (int c = 0; c < 4; c++)
    begin
      // indices 0, 5, 10, 15 reach both ends of the select field
      ctrl = {4'(c * 5), 2'(c), 2'b01};
      wreg(OFS_TPL_TEST_CONTROL, ctrl);
      rchk(OFS_TPL_TEST_CONTROL, ctrl);
      u_jesd_tx_model.send_sample(16'h1234, 2'(c), 4'(c * 5));
      u_jesd_tx_model.send_sample(16'h1235, 2'(c), 4'(c * 5 + 1));
      u_jesd_tx_model.send_sample(16'h1230, 2'(c + 1), 4'(c * 5));
      check(mis, 1'b0, "match or unselected");
      u_jesd_tx_model.send_sample(16'h9234, 2'(c), 4'(c * 5));
      check(mis, 1'b1, "mismatch flag");
      rchk(OFS_TPL_RESULT, 8'h01);
      wreg(OFS_TPL_TEST_CONTROL, ctrl | 8'h02);
      u_jesd_tx_model.send_sample(16'h0000, 2'(c), 4'(c * 5));
      rchk(OFS_TPL_RESULT, 8'h00);
      wreg(OFS_TPL_TEST_CONTROL, ctrl);
      u_jesd_tx_model.send_sample(16'h12b4, 2'(c), 4'(c * 5));
      check(mis, 1'b1, "low byte mismatch");
      wreg(OFS_TPL_TEST_CONTROL, ctrl & 8'hfe);
      u_jesd_tx_model.send_sample(16'h0000, 2'(c), 4'(c * 5));
      rchk(OFS_TPL_RESULT, 8'h00);
    end
    // downstream stalls while the fifo fills
    for (int i = 0; i < 8; i++)
    begin
      u_jesd_tx_model.push(64'h0123456789abcdef + 64'(i), ok);
      check(ok, 1'b1, "push accepted");
    end
    check(lrdy, 1'b0, "fifo full");
    lanes_ready = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      check(lov, 1'b1, "head valid");
      check(lod, flip(64'h0123456789abcdef + 64'(i), 8'ha5), "lane flip");
      @(posedge clk_sys_in);
      #1;
    end
    lanes_ready = 1'b0;
    check(lov, 1'b0, "fifo empty");
    for (int k = 0; k < 3; k++)
    begin
      u_jesd_tx_model.send_cfg(8'(8'h5a + k), 8'(8'hc3 - k), k[0], ~k[0], 5'(k * 9 + 4), ~k[0], lcs[k], fs[k]);
      wreg(OFS_RX_CFG_DEVICE_ID, 8'hff);
      rchk(OFS_RX_CFG_DEVICE_ID, 8'(8'h5a + k));
      rchk(OFS_RX_CFG_BANK_ID, 8'(8'hc3 - k));
      rchk(OFS_RX_CFG_LANE_ID_ADJUST, {1'b0, k[0], ~k[0], 5'(k * 9 + 4)});
      rchk(OFS_RX_CFG_SCRAMBLE_LANES, {~k[0], 2'b00, lcs[k]});
      rchk(OFS_RX_CFG_OCTETS_PER_FRAME, fs[k]);
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
